/* src/vip_unit.sv */
/*
  Vectored interrupt priority unit: merges peripheral flags into 17 event
  sources, arbitrates them with software interrupts, exceptions and traps,
  presents one vector to the core, and runs idle/power-down control.
  Assumes synchronous inputs; core samples vector while irq_req_out is high
  and peripherals clear their own flags once serviced.
*/
`timescale 1ns/10ps
`default_nettype none
module vip_unit
  import vip_pkg::*;
(
  input  wire logic                      clk_in,       // system clock
  input  wire logic                      rst_n_in,     // async reset, low
  input  wire vip_flags_t                flags_in,     // peripheral flags
  input  wire vip_exc_t                  exc_in,       // exceptions, traps
  input  wire logic [EN_LOW_W-1:0]       irq_enable_low_reg_in,  // low enables
  input  wire logic [EN_HIGH_W-1:0]      irq_enable_high_reg_in, // high enables
  input  wire logic [N_EVT*PRIO_W-1:0]   event_priority_in,      // 3b fields
  input  wire logic [EFF_W-1:0]          cpu_priority_mask_in,   // core mask
  input  wire logic [N_SWI-1:0]          soft_irq_request_in,    // swi 1..7
  input  wire logic [N_SWI-1:0]          soft_irq_enable_in,     // swi enables
  input  wire logic                      idle_req_in,  // enter idle
  input  wire logic                      pdown_req_in, // enter power-down
  output logic                           irq_req_out,  // request to core
  output logic [VEC_W-1:0]               vector_out,   // chosen vector
  output logic [EFF_W-1:0]               prio_out,     // chosen priority
  output logic                           is_exc_out,   // exception/trap/reset
  output logic                           osc_enable_out, // oscillator run
  output logic                           periph_run_out, // peripheral clocks
  output logic                           cpu_run_out     // core clock
);

  vip_state_t state;
  vip_state_t next_state;

  // field 0 disables; others sit in the upper half of the 4-bit scale
  function automatic logic [EFF_W-1:0] eff_prio(input logic [PRIO_W-1:0] f);
    if (f == '0) begin
      eff_prio = EFF_NONE;
    end else begin
      eff_prio = EFF_OFFSET | EFF_W'(f);
    end
  endfunction : eff_prio

  // slot n of a 4-byte vector table
  function automatic logic [VEC_W-1:0] slot(input logic [VEC_W-1:0] base,
                                            input int unsigned n);
    slot = base + VEC_W'(n) * VEC_STEP;
  endfunction : slot

  logic [N_EVT-1:0] evt_flag;
  logic [N_EVT-1:0] evt_en;
  logic             global_en;

  always_comb begin
    evt_flag = {
      flags_in.two_wire,
      flags_in.counter_channel_flags,
      flags_in.serial1_tx,
      flags_in.serial1_rx,
      flags_in.serial0_tx,
      flags_in.serial0_rx,
      flags_in.converter_done_flag,
      (|flags_in.counter_channel_flags)
        | flags_in.counter_array_overflow_flag,
      flags_in.timer2_overflow_flag | flags_in.timer2_external_flag,
      flags_in.timer1,
      flags_in.ext_irq1_pin,
      flags_in.timer0,
      flags_in.ext_irq0_pin
    };
    evt_en = {irq_enable_high_reg_in,
              irq_enable_low_reg_in[EN_LOW_SRC-1:0]};
  end

  assign global_en = irq_enable_low_reg_in[GLOBAL_BIT];

  // arbitration result, combinational
  logic             win_valid;
  logic [VEC_W-1:0] win_vec;
  logic [EFF_W-1:0] win_prio;
  logic             win_exc;
  logic             pin_wake;

  always_comb begin
    logic [EFF_W-1:0] p;
    p         = EFF_NONE;
    win_valid = 1'b0;
    win_vec   = VEC_RESET;
    win_prio  = EFF_NONE;
    win_exc   = 1'b0;
    pin_wake  = 1'b0;
    // index order is rank order, so strict compare keeps the lower rank
    for (int unsigned i = 0; i < N_EVT; i++) begin
      p = eff_prio(event_priority_in[i*PRIO_W +: PRIO_W]);
      if (evt_flag[i] && evt_en[i] && global_en
          && p > cpu_priority_mask_in && p > win_prio) begin
        win_valid = 1'b1;
        win_prio  = p;
        if (i < EVT_MID_SPLIT) begin
          win_vec = slot(VEC_EVT_LO, i);
        end else if (i < EVT_SPLIT) begin
          // serial slots restart at 00a0, so 009c stays unused
          win_vec = slot(VEC_EVT_MID, i - EVT_MID_SPLIT);
        end else begin
          win_vec = slot(VEC_EVT_HI, i - EVT_SPLIT);
        end
      end
    end
    for (int unsigned s = 0; s < N_SWI; s++) begin
      p = EFF_W'(s + 1);
      if (soft_irq_request_in[s] && soft_irq_enable_in[s]
          && p > cpu_priority_mask_in && p > win_prio) begin
        win_valid = 1'b1;
        win_prio  = p;
        win_vec   = slot(VEC_SWI, s);
      end
    end
    // rank 1: traps lowest, then exceptions, first in vector order wins
    if (exc_in.trap_req) begin
      win_valid = 1'b1;
      win_exc   = 1'b1;
      win_vec   = slot(VEC_TRAP, exc_in.trap_num);
    end
    for (int s = N_EXC - 1; s >= 0; s--) begin
      if (exc_in.exc_req[s]) begin
        win_valid = 1'b1;
        win_exc   = 1'b1;
        win_vec   = slot(VEC_EXC_BASE, s);
      end
    end
    if (exc_in.soft_reset_req) begin
      win_valid = 1'b1;
      win_exc   = 1'b1;
      win_vec   = VEC_RESET;
    end
    if (win_exc) begin
      win_prio = EFF_NONE;
    end
    // pins 0 and 1 are event slots 0 and 2
    p = eff_prio(event_priority_in[0 +: PRIO_W]);
    if (flags_in.ext_irq0_pin && evt_en[0] && global_en
        && p > cpu_priority_mask_in) begin
      pin_wake = 1'b1;
    end
    p = eff_prio(event_priority_in[2*PRIO_W +: PRIO_W]);
    if (flags_in.ext_irq1_pin && evt_en[2] && global_en
        && p > cpu_priority_mask_in) begin
      pin_wake = 1'b1;
    end
  end

  // wake logic must sit on an always-on clock; the oscillator
  // enable only gates what the rest of the chip runs from
  always_comb begin
    next_state = state;
    unique case (state.mode)
      VIP_RUN: begin
        next_state.irq_req = win_valid;
        next_state.vector  = win_vec;
        next_state.prio    = win_prio;
        next_state.is_exc  = win_exc;
        if (pdown_req_in) begin
          next_state.mode       = VIP_PDOWN;
          next_state.osc_enable = 1'b0;
          next_state.periph_run = 1'b0;
          next_state.cpu_run    = 1'b0;
        end else if (idle_req_in) begin
          next_state.mode       = VIP_IDLE;
          next_state.periph_run = 1'b1;
          next_state.cpu_run    = 1'b0;
        end
      end
      VIP_IDLE: begin
        next_state.irq_req = win_valid;
        next_state.vector  = win_vec;
        next_state.prio    = win_prio;
        next_state.is_exc  = win_exc;
        if (win_valid) begin
          next_state.mode    = VIP_RUN;
          next_state.cpu_run = 1'b1;
        end
      end
      VIP_PDOWN: begin
        // everything else held as it was on entry
        if (pin_wake) begin
          next_state.mode       = VIP_RUN;
          next_state.osc_enable = 1'b1;
          next_state.periph_run = 1'b1;
          next_state.cpu_run    = 1'b1;
        end
      end
      default: begin
        next_state.mode = VIP_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state.mode       <= VIP_RUN;
      state.irq_req    <= 1'b0;
      state.vector     <= VEC_RESET;
      state.prio       <= EFF_NONE;
      state.is_exc     <= 1'b0;
      state.osc_enable <= 1'b1;
      state.periph_run <= 1'b1;
      state.cpu_run    <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign irq_req_out    = state.irq_req;
  assign vector_out     = state.vector;
  assign prio_out       = state.prio;
  assign is_exc_out     = state.is_exc;
  assign osc_enable_out = state.osc_enable;
  assign periph_run_out = state.periph_run;
  assign cpu_run_out    = state.cpu_run;

endmodule : vip_unit
`default_nettype wire

/* src/vip_pkg.sv */
/*
  Shared constants and carriers for the vectored interrupt priority unit:
  vector slots, priority mapping, source counts and the raw flag bundle.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package vip_pkg;
  localparam int unsigned N_EVT       = 17;
  localparam int unsigned N_SWI       = 7;
  localparam int unsigned N_EXC       = 5;
  localparam int unsigned VEC_W       = 16;
  localparam int unsigned PRIO_W      = 3;
  localparam int unsigned EFF_W       = 4;
  localparam int unsigned EN_LOW_W    = 8;
  localparam int unsigned EN_HIGH_W   = 10;
  localparam int unsigned EN_LOW_SRC  = 7;
  localparam int unsigned GLOBAL_BIT  = 7;
  localparam int unsigned EVT_SPLIT   = 11;
  localparam int unsigned EVT_MID_SPLIT = 7;

  localparam logic [EFF_W-1:0] EFF_OFFSET   = 4'h8;
  localparam logic [EFF_W-1:0] EFF_NONE     = 4'h0;
  localparam logic [VEC_W-1:0] VEC_RESET    = 16'h0000;
  localparam logic [VEC_W-1:0] VEC_EXC_BASE = 16'h0004;
  localparam logic [VEC_W-1:0] VEC_TRAP     = 16'h0040;
  localparam logic [VEC_W-1:0] VEC_EVT_LO   = 16'h0080;
  localparam logic [VEC_W-1:0] VEC_EVT_MID  = 16'h00a0;
  localparam logic [VEC_W-1:0] VEC_EVT_HI   = 16'h00c0;
  localparam logic [VEC_W-1:0] VEC_SWI      = 16'h0100;
  localparam logic [VEC_W-1:0] VEC_STEP     = 16'h0004;

  typedef enum logic [1:0] {
    VIP_RUN,
    VIP_IDLE,
    VIP_PDOWN
  } vip_mode_t;

  // raw peripheral flags, before the shared-source merge
  typedef struct packed {
    logic       ext_irq0_pin;
    logic       timer0;
    logic       ext_irq1_pin;
    logic       timer1;
    logic       timer2_overflow_flag;
    logic       timer2_external_flag;
    logic       counter_array_overflow_flag;
    logic [4:0] counter_channel_flags;
    logic       converter_done_flag;
    logic       serial0_rx;
    logic       serial0_tx;
    logic       serial1_rx;
    logic       serial1_tx;
    logic       two_wire;
  } vip_flags_t;

  // exceptions in vector order: breakpoint, trace, stack, divide, return
  typedef struct packed {
    logic [N_EXC-1:0] exc_req;
    logic             trap_req;
    logic [3:0]       trap_num;
    logic             soft_reset_req;
  } vip_exc_t;

  typedef struct packed {
    vip_mode_t        mode;
    logic             irq_req;
    logic [VEC_W-1:0] vector;
    logic [EFF_W-1:0] prio;
    logic             is_exc;
    logic             osc_enable;
    logic             periph_run;
    logic             cpu_run;
  } vip_state_t;
endpackage : vip_pkg

/* bench/vip_unit_asserts.sv */
/*
  Checker for vip_unit, watching top-level ports only.
  Assumes the bind at the foot attaches it to every vip_unit.
*/
`timescale 1ns/10ps
`default_nettype none
module vip_asserts
  import vip_pkg::*;
(
  input wire logic                clk_in,                // clock
  input wire logic                rst_n_in,              // reset
  input wire vip_flags_t          flags_in,              // flags
  input wire vip_exc_t            exc_in,                // exceptions
  input wire logic [EN_LOW_W-1:0] irq_enable_low_reg_in, // enables
  input wire logic [EFF_W-1:0]    cpu_priority_mask_in,  // mask
  input wire logic [N_SWI-1:0]    soft_irq_request_in,   // swi
  input wire logic                idle_req_in,           // idle
  input wire logic                pdown_req_in,          // power-down
  input wire logic                irq_req_out,           // request
  input wire logic [VEC_W-1:0]    vector_out,            // vector
  input wire logic [EFF_W-1:0]    prio_out,              // priority
  input wire logic                is_exc_out,            // exception
  input wire logic                osc_enable_out,        // oscillator
  input wire logic                periph_run_out,        // peripherals
  input wire logic                cpu_run_out            // core
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic awake;
  assign awake = osc_enable_out && !pdown_req_in;
  sequence s_quiet;
    awake && exc_in == '0 && soft_irq_request_in == '0;
  endsequence
  sequence s_idle_go;
    cpu_run_out && idle_req_in && !pdown_req_in;
  endsequence
  a_global_gate: assert property (
    s_quiet ##0 !irq_enable_low_reg_in[GLOBAL_BIT] |=> !irq_req_out)
    else $error("request with global enable off");
  a_reset_vector: assert property (
    awake && exc_in.soft_reset_req |=> irq_req_out && is_exc_out
      && vector_out == VEC_RESET) else $error("reset vector wrong");
  a_exc_vector: assert property (
    awake && exc_in.exc_req[0] && !exc_in.soft_reset_req
      |=> is_exc_out && vector_out == VEC_EXC_BASE)
    else $error("breakpoint vector wrong");
  a_eff_levels: assert property (
    irq_req_out && !is_exc_out |-> prio_out != 4'h0 && prio_out != 4'h8)
    else $error("impossible priority presented");
  a_above_mask: assert property (
    awake ##1 (irq_req_out && !is_exc_out)
      |-> prio_out > $past(cpu_priority_mask_in))
    else $error("request not above mask");
  a_pdown_enter: assert property (
    cpu_run_out && osc_enable_out && pdown_req_in
      |=> !osc_enable_out && !periph_run_out && !cpu_run_out)
    else $error("power-down not entered");
  a_pdown_hold: assert property (
    !osc_enable_out && !flags_in.ext_irq0_pin && !flags_in.ext_irq1_pin
      |=> !osc_enable_out && $stable(vector_out) && $stable(prio_out))
    else $error("power-down left or state changed");
  a_idle_periph: assert property (
    s_idle_go |=> periph_run_out && osc_enable_out)
    else $error("peripherals stopped in idle");
  a_idle_wake: assert property (
    !cpu_run_out && periph_run_out && exc_in.soft_reset_req |=> cpu_run_out)
    else $error("idle not left on request");
endmodule : vip_asserts
bind vip_unit vip_asserts u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .flags_in(flags_in),
  .exc_in(exc_in), .irq_enable_low_reg_in(irq_enable_low_reg_in),
  .cpu_priority_mask_in(cpu_priority_mask_in),
  .soft_irq_request_in(soft_irq_request_in), .idle_req_in(idle_req_in),
  .pdown_req_in(pdown_req_in), .irq_req_out(irq_req_out),
  .vector_out(vector_out), .prio_out(prio_out), .is_exc_out(is_exc_out),
  .osc_enable_out(osc_enable_out), .periph_run_out(periph_run_out),
  .cpu_run_out(cpu_run_out));
`default_nettype wire

/* bench/vip_core_model.sv */
/*
  Core-side model: takes the presented vector while the core runs.
  Assumes registered request and vector from the interrupt unit.
*/
`timescale 1ns/10ps
`default_nettype none
module vip_core_model (
  input  wire logic        clk_in,        // clock
  input  wire logic        rst_n_in,      // reset
  input  wire logic        irq_req_in,    // request
  input  wire logic [15:0] vector_in,     // vector
  input  wire logic        cpu_run_in,    // core clock on
  output var  logic [15:0] taken_vec_out  // last vector taken
);
  // a halted core cannot fetch, so only a running core takes vectors
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      taken_vec_out <= 16'h0000;
    else if (irq_req_in && cpu_run_in)
      taken_vec_out <= vector_in;
  end
endmodule : vip_core_model
`default_nettype wire

/* bench/vip_unit_tb_top.sv */
/*
  Testbench for vip_unit: drives flags, enables, modes; checks vectors.
  Assumes the checker binds itself and the core model sits on the outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module vip_unit_tb_top;
  import vip_pkg::*;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, idl = 1'b0, pdn = 1'b0;
  vip_flags_t  flg = '0, f;
  vip_exc_t    exc = '0;
  logic [7:0]  enl = '0;
  logic [9:0]  enh = '0;
  logic [50:0] pri = '0;
  logic [3:0]  msk = '0, prio;
  logic [6:0]  swr = '0, swe = '0;
  logic [16:0] en;
  logic        irq, isx, osc, per, cpu;
  logic [15:0] vec, tvec, want;
  int          failures = 0, n_compared = 0;
  always #5 clk_in = ~clk_in;
  vip_unit dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .flags_in(flg),
    .exc_in(exc), .irq_enable_low_reg_in(enl), .irq_enable_high_reg_in(enh),
    .event_priority_in(pri), .cpu_priority_mask_in(msk),
    .soft_irq_request_in(swr), .soft_irq_enable_in(swe), .idle_req_in(idl),
    .pdown_req_in(pdn), .irq_req_out(irq), .vector_out(vec),
    .prio_out(prio), .is_exc_out(isx), .osc_enable_out(osc),
    .periph_run_out(per), .cpu_run_out(cpu));
  vip_core_model u_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .irq_req_in(irq), .vector_in(vec), .cpu_run_in(cpu),
    .taken_vec_out(tvec));
  // wide enough for the packed {prio, vector} compares
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic nxt; // let the edge's updates land before looking
    @(posedge clk_in);
    #1;
  endtask : nxt
  task automatic evt(input vip_flags_t ff, input logic [7:0] l,
    input logic [9:0] h, input logic [50:0] p, input logic [3:0] m);
    @(posedge clk_in);
    flg <= ff;
    enl <= l;
    enh <= h;
    pri <= p;
    msk <= m;
    pdn <= 1'b0;
    idl <= 1'b0;
    nxt;
  endtask : evt
  task automatic report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    nxt;
    chk({irq, osc, per, cpu}, 4'h7);
    chk(vec, 16'h0000);
    for (int i = 0; i < 17; i++) begin
      en = 17'h1 << i;
      want = i < 7 ? 16'h0080 + 16'(4 * i) : i < 11 ?
        16'h00a0 + 16'(4 * (i - 7)) : 16'h00c0 + 16'(4 * (i - 11));
      evt('1, {1'b1, en[6:0]}, en[16:7], {17{3'h1}}, 4'h8);
      chk(vec, want);
      chk({irq, prio}, 5'h19);
    end
    evt('1, 8'h7f, 10'h3ff, {17{3'h7}}, 4'h0);
    chk(irq, 1'b0);
    evt('1, 8'hff, 10'h3ff, '0, 4'h0);
    chk(irq, 1'b0);
    for (int v = 1; v < 8; v++) begin
      evt('1, 8'hff, 10'h3ff, {17{3'(v)}}, 4'(v + 7));
      chk(vec, 16'h0080);
      chk(prio, 16'(v + 8));
      evt('1, 8'hff, 10'h3ff, {17{3'(v)}}, 4'(v + 8));
      chk(irq, 1'b0);
    end
    evt('1, 8'hff, 10'h3ff, {3'h7, {16{3'h1}}}, 4'h0);
    chk({prio, vec}, 20'hf00d4);
    for (int k = 0; k < 2; k++) begin
      f = '0;
      f.timer2_external_flag = (k == 0);
      f.counter_array_overflow_flag = (k == 1);
      evt(f, 8'hff, 10'h3ff, {17{3'h1}}, 4'h0);
      chk(vec, 16'h0090 + 16'(4 * k));
    end
    evt('0, 8'h80, 10'h0, '0, 4'h0);
    for (int s = 1; s < 8; s++) begin
      @(posedge clk_in);
      swr <= 7'(1 << (s - 1));
      swe <= 7'h7f;
      nxt;
      chk({prio, vec}, {4'(s), 16'h0100 + 16'(4 * (s - 1))});
    end
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_in);
      exc <= {5'(32'h1 << k), 1'b1, 4'hf, k == 6};
      nxt;
      want = k < 5 ? 16'h0004 + 16'(4 * k) : k == 5 ? 16'h007c : 16'h0;
      chk(vec, want);
      chk({isx, prio}, 5'h10);
    end
    @(posedge clk_in);
    exc <= '0;
    swr <= '0;
    idl <= 1'b1;
    nxt;
    chk({osc, per, cpu}, 3'b110);
    @(posedge clk_in);
    swr <= 7'h4;
    idl <= 1'b0;
    nxt;
    chk({cpu, irq, vec}, 18'h30108);
    @(posedge clk_in);
    swr <= '0;
    pdn <= 1'b1;
    nxt;
    chk({osc, per, cpu}, 3'b000);
    f = '0;
    f.ext_irq1_pin = 1'b1;
    evt(f, 8'h80, 10'h0, {17{3'h1}}, 4'h0);
    chk(osc, 1'b0);
    evt(f, 8'h84, 10'h0, {17{3'h1}}, 4'h9);
    chk(osc, 1'b0);
    evt(f, 8'h84, 10'h0, {17{3'h1}}, 4'h8);
    nxt;
    chk({osc, per, cpu}, 3'b111);
    nxt;
    chk(vec, 16'h0088);
    nxt;
    chk(tvec, 16'h0088);
    report_and_stop;
  end
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
endmodule : vip_unit_tb_top
`default_nettype wire
